//--- kr_lt_pkg.sv
// Package with register map, field layout and reset values of the link-training status block.
package kr_lt_pkg;
	// Printed offsets are word indices; byte address is four times the index.
	localparam logic [11:0] status_index = 12'h4D2;
	localparam logic [11:0] window_index = 12'h4D3;
	localparam logic [11:0] coef_index = 12'h4D4;
	localparam logic [11:0] control_index = 12'h4D1;
	localparam logic [11:0] irq_status_index = 12'h4E0;
	localparam logic [11:0] irq_mask_index = 12'h4E1;
	localparam logic [13:0] status_addr = {status_index, 2'b00};
	localparam logic [13:0] window_addr = {window_index, 2'b00};
	localparam logic [13:0] coef_addr = {coef_index, 2'b00};
	localparam logic [13:0] control_addr = {control_index, 2'b00};
	localparam logic [13:0] irq_status_addr = {irq_status_index, 2'b00};
	localparam logic [13:0] irq_mask_addr = {irq_mask_index, 2'b00};
	localparam int status_bits = 8;
	localparam int frames_lsb = 0;
	localparam int k_frames_lsb = 10;
	localparam int m_frames_lsb = 20;
	localparam int count_width = 10;
	localparam logic [9:0] frames_reset = 10'h000;
	localparam logic [9:0] k_frames_reset = 10'h00F;
	localparam logic [9:0] m_frames_reset = 10'h000;
	localparam logic [7:0] coef_reset = 8'h00;
	localparam int override_bit = 16;
	localparam int send_new_bit = 4;
	localparam logic [1:0] req_hold = 2'h0;
	localparam logic [1:0] req_increment = 2'h1;
	localparam logic [1:0] req_decrement = 2'h2;
	localparam logic [1:0] req_reserved = 2'h3;
	localparam int init_bit = 6;
	localparam int preset_bit = 7;
endpackage : kr_lt_pkg

//--- coef_request_reg.sv
// Coefficient request register: mirrors training logic or takes software writes.
module coef_request_reg
	import kr_lt_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic override_enable,
	input wire logic sw_write,
	input wire logic [7:0] sw_data,
	input wire logic [7:0] logic_request,
	output logic [7:0] request
);
	logic [7:0] next_request;

	// Reserved tap code 11 from software is turned into hold so it never leaves.
	function automatic logic [1:0] clean_tap(input logic [1:0] code);
		clean_tap = (code == req_reserved) ? req_hold : code;
	endfunction : clean_tap

	always_comb begin
		next_request = request;
		if (!override_enable) begin
			next_request = logic_request;
		end else if (sw_write) begin
			next_request = {sw_data[preset_bit], sw_data[init_bit],
				clean_tap(sw_data[5:4]), clean_tap(sw_data[3:2]),
				clean_tap(sw_data[1:0])};
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			request <= coef_reset;
		end else begin
			request <= next_request;
		end
	end
endmodule : coef_request_reg

//--- kr_link_training_status_ber_coef.sv
// Register bank for link-training status, error window length and coefficient request.
// Operation
// - Bit 0 shows receiver trained.
// - Bit 1 shows training frame lock.
// - Bit 2 high while start-up runs.
// - Bit 3 shows training failure.
// - Bit 4 shows excessive error rate.
// - Bit 5 shows frame lock lost.
// - Bit 6 shows lock loss during receive equalization.
// - Bit 7 shows fine tuning found nothing.
// - Bits 9:0 frames per step.
// - Bits 19:10 thousands of frames, reset 0xF.
// - Bits 29:20 millions of frames.
// - Bits 5:0 mirror outgoing word, writable under override.
// - Tap codes: 01 up, 10 down, 00 hold.
// - Bit 6 requests partner initialize.
// - Bit 7 requests partner preset.
// - Override bit hands commands to software.
// - Self-clearing bit sends software request.
//
// The implementer's own choice: the AHB-Lite slave port.
module kr_link_training_status_ber_coef
	import kr_lt_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic rx_trained,
	input wire logic frame_lock,
	input wire logic startup_running,
	input wire logic training_failure,
	input wire logic error_excessive,
	input wire logic frame_lock_lost,
	input wire logic receive_equalization_phase_lock_loss,
	input wire logic tuning_error,
	input wire logic [7:0] logic_request,
	output logic [7:0] local_side_request,
	output logic send_request,
	output logic override_enable,
	output logic [9:0] frames_count,
	output logic [9:0] k_frames_count,
	output logic [9:0] m_frames_count,
	output logic irq
);
	logic [status_bits-1:0] status_live;
	logic [status_bits-1:0] status_prev;
	logic [status_bits-1:0] next_status_prev;
	logic [status_bits-1:0] irq_status;
	logic [status_bits-1:0] next_irq_status;
	logic [status_bits-1:0] irq_mask;
	logic [status_bits-1:0] next_irq_mask;
	logic [9:0] next_frames_count;
	logic [9:0] next_k_frames_count;
	logic [9:0] next_m_frames_count;
	logic next_override_enable;
	logic next_send_request;
	logic next_irq;
	logic [31:0] next_hrdata;
	logic wr_pending;
	logic next_wr_pending;
	logic [13:0] wr_addr;
	logic [13:0] next_wr_addr;
	logic rd_now;
	logic wr_now;
	logic coef_write;
	logic [7:0] coef_value;
	logic [status_bits-1:0] status_rise;
	logic window_write;
	logic control_write;
	logic irq_status_write;
	logic irq_mask_write;
	logic next_hreadyout;
	logic next_hresp;
	logic [7:0] next_local_side_request;

	// Reads decode all address bits so upper bits alias nothing; writes compare haddr[13:0] only.
	function automatic logic hit(input logic [31:0] a, input logic [13:0] r);
		hit = (a[31:14] == 18'h00000) && (a[13:0] == r);
	endfunction : hit

	// A data phase write lands only on the register its address phase named.
	function automatic logic write_to(input logic pending,
		input logic [13:0] a, input logic [13:0] r);
		write_to = pending && (a == r);
	endfunction : write_to

	function automatic logic [31:0] low_byte(input logic [7:0] v);
		low_byte = {24'h000000, v};
	endfunction : low_byte

	function automatic logic [9:0] count_field(input logic [31:0] d,
		input int lsb);
		count_field = d[lsb +: count_width];
	endfunction : count_field

	// Status bits are straight copies of the training state each cycle.
	assign status_live = {tuning_error, receive_equalization_phase_lock_loss, frame_lock_lost,
		error_excessive, training_failure, startup_running, frame_lock,
		rx_trained};

	assign rd_now = hsel && hready && htrans[1] && !hwrite;
	assign wr_now = hsel && hready && htrans[1] && hwrite;
	assign coef_write = write_to(wr_pending, wr_addr, coef_addr);
	assign window_write = write_to(wr_pending, wr_addr, window_addr);
	assign control_write = write_to(wr_pending, wr_addr, control_addr);
	assign irq_status_write = write_to(wr_pending, wr_addr, irq_status_addr);
	assign irq_mask_write = write_to(wr_pending, wr_addr, irq_mask_addr);
	assign status_rise = status_live & ~status_prev;

	coef_request_reg u_coef (
		.hclk(hclk),
		.hresetn(hresetn),
		.override_enable(override_enable),
		.sw_write(coef_write),
		.sw_data(hwdata[7:0]),
		.logic_request(logic_request),
		.request(coef_value)
	);

	// The address phase is remembered so the write lands in its data phase.
	always_comb begin
		next_wr_pending = wr_now;
		next_wr_addr = wr_addr;
		if (wr_now) begin
			next_wr_addr = haddr[13:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pending <= 1'b0;
			wr_addr <= 14'h0000;
		end else begin
			wr_pending <= next_wr_pending;
			wr_addr <= next_wr_addr;
		end
	end

	always_comb begin
		next_frames_count = frames_count;
		next_k_frames_count = k_frames_count;
		next_m_frames_count = m_frames_count;
		if (window_write) begin
			next_frames_count = count_field(hwdata, frames_lsb);
			next_k_frames_count = count_field(hwdata, k_frames_lsb);
			next_m_frames_count = count_field(hwdata, m_frames_lsb);
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			frames_count <= frames_reset;
			k_frames_count <= k_frames_reset;
			m_frames_count <= m_frames_reset;
		end else begin
			frames_count <= next_frames_count;
			k_frames_count <= next_k_frames_count;
			m_frames_count <= next_m_frames_count;
		end
	end

	always_comb begin
		next_override_enable = override_enable;
		if (control_write) begin
			next_override_enable = hwdata[override_bit];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			override_enable <= 1'b0;
		end else begin
			override_enable <= next_override_enable;
		end
	end

	// Send needs the override already on, so one write cannot both enable
	// the override and ship a field that software has not yet filled in.
	always_comb begin
		next_send_request = 1'b0;
		if (control_write) begin
			next_send_request = hwdata[send_new_bit] && override_enable;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			send_request <= 1'b0;
		end else begin
			send_request <= next_send_request;
		end
	end

	always_comb begin
		next_status_prev = status_live;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			status_prev <= 8'h00;
		end else begin
			status_prev <= next_status_prev;
		end
	end

	always_comb begin
		next_irq_mask = irq_mask;
		if (irq_mask_write) begin
			next_irq_mask = hwdata[status_bits-1:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_mask <= 8'h00;
		end else begin
			irq_mask <= next_irq_mask;
		end
	end

	// A rising status bit sets its sticky flag; set wins over a same-cycle clear.
	always_comb begin
		next_irq_status = irq_status;
		if (irq_status_write) begin
			next_irq_status = irq_status & ~hwdata[status_bits-1:0];
		end
		next_irq_status = next_irq_status | status_rise;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_status <= 8'h00;
		end else begin
			irq_status <= next_irq_status;
		end
	end

	// Built from the next flags so the line moves in step with them.
	always_comb begin
		next_irq = |(next_irq_status & next_irq_mask);
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq <= 1'b0;
		end else begin
			irq <= next_irq;
		end
	end

	// Read data stands for the data phase only and is zero otherwise.
	always_comb begin
		next_hrdata = 32'h00000000;
		if (rd_now) begin
			if (hit(haddr, status_addr)) begin
				next_hrdata = low_byte(status_live);
			end else if (hit(haddr, window_addr)) begin
				next_hrdata = {2'b00, m_frames_count, k_frames_count,
					frames_count};
			end else if (hit(haddr, coef_addr)) begin
				next_hrdata = low_byte(coef_value);
			end else if (hit(haddr, control_addr)) begin
				next_hrdata = {15'h0000, override_enable, 16'h0000};
			end else if (hit(haddr, irq_status_addr)) begin
				next_hrdata = low_byte(irq_status);
			end else if (hit(haddr, irq_mask_addr)) begin
				next_hrdata = low_byte(irq_mask);
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h00000000;
		end else begin
			hrdata <= next_hrdata;
		end
	end

	// Every transfer is answered at once with OKAY; no wait state exists.
	always_comb begin
		next_hreadyout = 1'b1;
		next_hresp = 1'b0;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= next_hreadyout;
			hresp <= next_hresp;
		end
	end

	// One more register so the outgoing word leaves straight from a flop.
	always_comb begin
		next_local_side_request = coef_value;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			local_side_request <= coef_reset;
		end else begin
			local_side_request <= next_local_side_request;
		end
	end
endmodule : kr_link_training_status_ber_coef

//--- training_far_end.sv
// Far-end training logic model: live status flags and tap requests.
module training_far_end (
	input wire logic hclk,
	output logic [7:0] flags,
	output logic [7:0] logic_request
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		flags = 8'h00;
		logic_request = 8'h00;
	end
	// Callers never pass the reserved tap code 11.
	task automatic drive(input logic [7:0] f, input logic [7:0] q);
		@(posedge hclk);
		flags <= f;
		logic_request <= q;
	endtask : drive
endmodule : training_far_end

//--- kr_lt_monitor.sv
// Checker of bus answers, field updates and request path of the bank.
module kr_lt_monitor
	import kr_lt_pkg::*;
(
	input wire logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp,
	input wire logic [31:0] haddr, hwdata, hrdata,
	input wire logic [1:0] htrans,
	input wire logic rx_trained, frame_lock, startup_running, training_failure,
	input wire logic error_excessive, frame_lock_lost, receive_equalization_phase_lock_loss,
	input wire logic tuning_error, send_request, override_enable,
	input wire logic [7:0] logic_request, local_side_request,
	input wire logic [9:0] frames_count, k_frames_count, m_frames_count
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic take;
	logic rd;
	logic [7:0] flags;
	assign take = hsel && hready && htrans[1];
	assign rd = take && !hwrite;
	assign flags = {tuning_error, receive_equalization_phase_lock_loss, frame_lock_lost,
		error_excessive, training_failure, startup_running, frame_lock,
		rx_trained};
	chk_ready_okay: assert property (hreadyout && !hresp)
		else $error("bus answer not zero-wait OKAY");
	chk_status_read: assert property (rd && haddr == {18'h0, status_addr}
		|=> hrdata == {24'h0, $past(flags)}) else $error("status read wrong");
	chk_window_write: assert property (take && hwrite &&
		haddr == {18'h0, window_addr} |=> ##1
		{m_frames_count, k_frames_count, frames_count} == $past(hwdata[29:0]))
		else $error("window fields not written");
	chk_follow_logic: assert property (!override_enable [*3] |->
		local_side_request == $past(logic_request, 2))
		else $error("request does not follow training logic");
	chk_send_pulse: assert property (send_request |->
		$past(override_enable) ##1 !send_request)
		else $error("send pulse wrong");
	chk_override_bit: assert property (take && hwrite &&
		haddr == {18'h0, control_addr} |=> ##1
		override_enable == $past(hwdata[override_bit]))
		else $error("override bit not written");
	chk_unmapped_zero: assert property (rd && haddr == 32'h0 |=>
		hrdata == 32'h0) else $error("unmapped read not zero");
	chk_idle_zero: assert property (!$past(rd) |-> hrdata == 32'h0)
		else $error("read data outside data phase");
	cover property (send_request);
	cover property (rd && haddr == {18'h0, status_addr} ##1 hrdata != 32'h0);
	cover property (override_enable && local_side_request[init_bit]);
endmodule : kr_lt_monitor
bind kr_link_training_status_ber_coef kr_lt_monitor u_kr_lt_monitor (.*);

//--- test_kr_link_training_status_ber_coef.sv
// Testbench driving the register bank over the bus beside a far-end model.
module test_kr_link_training_status_ber_coef import kr_lt_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic hready, hreadyout, hresp, send_request, override_enable, irq;
	logic [7:0] flags, logic_request, local_side_request;
	logic [9:0] frames_count, k_frames_count, m_frames_count;
	logic rx_trained, frame_lock, startup_running, training_failure;
	logic error_excessive, frame_lock_lost, receive_equalization_phase_lock_loss, tuning_error;
	int num_errors = 0, checked = 0;
	assign hready = hreadyout;
	assign {tuning_error, receive_equalization_phase_lock_loss, frame_lock_lost, error_excessive,
		training_failure, startup_running, frame_lock, rx_trained} = flags;
	always #20 hclk = ~hclk;
	kr_link_training_status_ber_coef u_kr_link_training_status_ber_coef (.*);
	training_far_end u_training_far_end (.*);
	function automatic logic [31:0] ad(input logic [13:0] x);
		return {18'h0, x};
	endfunction : ad
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge hclk);
		htrans <= 2'h2;
		hsel <= 1'h1;
		haddr <= a;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'h1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'h1);
		r = hrdata;
	endtask : xfer
	task automatic rd(input logic [31:0] a, input logic [31:0] e);
		xfer(1'h0, a, 32'h0);
		chk(r, e);
	endtask : rd
	task automatic irq_is(input logic e);
		repeat (3) @(negedge hclk);
		chk({31'h0, irq}, {31'h0, e});
	endtask : irq_is
	task automatic pulses(input int n);
		int c = 0;
		repeat (4) @(negedge hclk) c += send_request;
		chk(c, n);
	endtask : pulses
	task automatic t_reset;
		rd(ad(window_addr), 32'h0000_3C00);
		xfer(1'h1, 32'h0, 32'hFFFF_FFFF);
		rd(32'h0, 32'h0);
	endtask : t_reset
	task automatic t_status;
		for (int i = 0; i < 8; i++) begin
			u_training_far_end.drive(8'h01 << i, 8'h00);
			rd(ad(status_addr), 32'h1 << i);
		end
	endtask : t_status
	task automatic t_window;
		xfer(1'h1, ad(window_addr), 32'h1234_5678);
		@(negedge hclk);
		chk({2'h0, m_frames_count, k_frames_count, frames_count}, 32'h1234_5678);
		rd(ad(window_addr), 32'h1234_5678);
	endtask : t_window
	task automatic t_coef;
		u_training_far_end.drive(8'h00, 8'h96);
		xfer(1'h1, ad(coef_addr), 32'h0);
		rd(ad(coef_addr), 32'h96);
		xfer(1'h1, ad(control_addr), 32'h0001_0000);
		xfer(1'h1, ad(coef_addr), 32'hB7);
		rd(ad(coef_addr), 32'h84);
		xfer(1'h1, ad(coef_addr), 32'h49);
		repeat (3) @(negedge hclk);
		chk({24'h0, local_side_request}, 32'h49);
		xfer(1'h1, ad(control_addr), 32'h0001_0010);
		pulses(1);
		xfer(1'h1, ad(control_addr), 32'h0);
		xfer(1'h1, ad(control_addr), 32'h10);
		pulses(0);
		rd(ad(control_addr), 32'h0);
	endtask : t_coef
	task automatic t_irq;
		u_training_far_end.drive(8'h00, 8'h00);
		xfer(1'h1, ad(irq_mask_addr), 32'h1);
		xfer(1'h1, ad(irq_status_addr), 32'hFF);
		irq_is(1'h0);
		u_training_far_end.drive(8'h04, 8'h00);
		irq_is(1'h0);
		u_training_far_end.drive(8'h05, 8'h00);
		irq_is(1'h1);
		rd(ad(irq_status_addr), 32'h5);
		xfer(1'h1, ad(irq_status_addr), 32'h5);
		irq_is(1'h0);
	endtask : t_irq
	task automatic t_midreset;
		@(posedge hclk);
		hresetn <= 1'h0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'h1;
		rd(ad(window_addr), 32'h0000_3C00);
		rd(ad(control_addr), 32'h0);
		rd(ad(irq_mask_addr), 32'h0);
		irq_is(1'h0);
	endtask : t_midreset
	task automatic end_of_test;
		$display("checked %0d num_errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : end_of_test
	initial begin
		repeat (8) @(posedge hclk);
		hresetn <= 1'h1;
		t_reset;
		t_status;
		t_window;
		t_coef;
		t_irq;
		t_midreset;
		end_of_test;
	end
	// The whole sequence needs well under 200 cycles; this span is generous.
	initial begin
		#200000;
		num_errors++;
		end_of_test;
	end
endmodule : test_kr_link_training_status_ber_coef
